/* logic/dtec_pkg.sv */
package dtec_pkg;
    // Machine cycle length in clock periods
    localparam int         MC_PERIODS  = 12;
    // Register offsets
    localparam logic [2:0] ADDR_MODE   = 3'h0;
    localparam logic [2:0] ADDR_CTRL   = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_MASK   = 3'h3;
    localparam logic [2:0] ADDR_C0LOW  = 3'h4;
    localparam logic [2:0] ADDR_C0HIGH = 3'h5;
    localparam logic [2:0] ADDR_C1LOW  = 3'h6;
    localparam logic [2:0] ADDR_C1HIGH = 3'h7;
    // Mode register layout, one nibble per counter
    localparam int         NIB_WIDTH   = 4;
    localparam int         GATE_POS    = 3;
    localparam int         SRC_POS     = 2;
    localparam int         MODE_POS    = 0;
    localparam int         MODE_WIDTH  = 2;
    // Run, flag and mask bit positions
    localparam int         CNT0_POS    = 0;
    localparam int         CNT1_POS    = 1;
    // Reset values
    localparam logic [7:0] MODE_RST    = 8'h00;
    localparam logic [1:0] CTRL_RST    = 2'h0;
    localparam logic [1:0] FLAG_RST    = 2'h0;
    localparam logic [1:0] MASK_RST    = 2'h0;
    localparam logic [7:0] COUNT_RST   = 8'h00;
    // Wrap points
    localparam logic [4:0] PRESC_MAX   = 5'h1F;
    localparam logic [7:0] BYTE_MAX    = 8'hFF;
    // Operating modes in mode field order
    typedef enum logic [1:0] {
        MODE_PRESCALE,
        MODE_CASCADE,
        MODE_RELOAD,
        MODE_SPLIT
    } dtec_mode_t;
endpackage : dtec_pkg

/* logic/dtec_unit_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dtec_unit_if;
    // Control toward one counter unit
    dtec_pkg::dtec_mode_t mode;
    logic                 tick;
    logic                 highTick;
    logic                 wrLow;
    logic                 wrHigh;
    logic [7:0]           wrData;
    // State back from the unit
    logic [7:0]           countLow;
    logic [7:0]           countHigh;
    logic                 ovf;
    logic                 ovfHigh;

    modport ctrl (output mode, tick, highTick, wrLow, wrHigh, wrData,
                  input  countLow, countHigh, ovf, ovfHigh);
    modport unit (input  mode, tick, highTick, wrLow, wrHigh, wrData,
                  output countLow, countHigh, ovf, ovfHigh);
endinterface : dtec_unit_if
`default_nettype wire

/* logic/dtec_count_unit.sv */
`timescale 1ns/100ps
`default_nettype none
module dtec_count_unit (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Controller side
    dtec_unit_if.unit bus
);
    logic [7:0] low_q;
    logic [7:0] low_d;
    logic [7:0] high_q;
    logic [7:0] high_d;
    logic       ovf;
    logic       ovfHigh;

    // Next count and overflow per mode; a byte write wins over counting
    always_comb begin
        low_d   = low_q;
        high_d  = high_q;
        ovf     = 1'b0;
        ovfHigh = 1'b0;
        case (bus.mode)
            dtec_pkg::MODE_PRESCALE: begin
                if (bus.tick) begin
                    low_d = {low_q[7:5], low_q[4:0] + 5'h01};
                    if (low_q[4:0] == dtec_pkg::PRESC_MAX) begin
                        high_d = high_q + 8'h01;
                        ovf    = (high_q == dtec_pkg::BYTE_MAX);
                    end
                end
            end
            dtec_pkg::MODE_CASCADE: begin
                if (bus.tick) begin
                    {high_d, low_d} = {high_q, low_q} + 16'h0001;
                    ovf = ({high_q, low_q} == {2{dtec_pkg::BYTE_MAX}});
                end
            end
            dtec_pkg::MODE_RELOAD: begin
                if (bus.tick) begin
                    ovf   = (low_q == dtec_pkg::BYTE_MAX);
                    low_d = ovf ? high_q : low_q + 8'h01;
                end
            end
            default: begin
                if (bus.tick) begin
                    low_d = low_q + 8'h01;
                    ovf   = (low_q == dtec_pkg::BYTE_MAX);
                end
                if (bus.highTick) begin
                    high_d  = high_q + 8'h01;
                    ovfHigh = (high_q == dtec_pkg::BYTE_MAX);
                end
            end
        endcase
        if (bus.wrLow || bus.wrHigh) begin
            ovf     = 1'b0;
            ovfHigh = 1'b0;
        end
        if (bus.wrLow) begin
            low_d = bus.wrData;
        end
        if (bus.wrHigh) begin
            high_d = bus.wrData;
        end
    end

    // Count bytes
    always_ff @(posedge clk) begin
        if (!rstn) begin
            low_q  <= dtec_pkg::COUNT_RST;
            high_q <= dtec_pkg::COUNT_RST;
        end else begin
            low_q  <= low_d;
            high_q <= high_d;
        end
    end

    // Back to the controller
    assign bus.countLow  = low_q;
    assign bus.countHigh = high_q;
    assign bus.ovf       = ovf;
    assign bus.ovfHigh   = ovfHigh;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_prescale;
        bus.mode == dtec_pkg::MODE_PRESCALE && bus.tick && !bus.wrLow && !bus.wrHigh
            && low_q[4:0] == 5'h1F |=> low_q[4:0] == 5'h00 && high_q == $past(high_q) + 8'h01;
    endproperty
    a_prescale: assert property (p_prescale) else $error("prescaler wrap missed");
    property p_cascade;
        bus.mode == dtec_pkg::MODE_CASCADE && bus.tick && !bus.wrLow && !bus.wrHigh
            |=> {high_q, low_q} == $past({high_q, low_q}) + 16'h0001;
    endproperty
    a_cascade: assert property (p_cascade) else $error("16-bit count wrong");
    property p_reload;
        bus.mode == dtec_pkg::MODE_RELOAD && bus.tick && !bus.wrLow && !bus.wrHigh
            && low_q == 8'hFF |-> ovf ##1 low_q == $past(high_q) && $stable(high_q);
    endproperty
    a_reload: assert property (p_reload) else $error("reload missed");
    c_reload: cover property (bus.mode == dtec_pkg::MODE_RELOAD && ovf);
endmodule : dtec_count_unit
`default_nettype wire

/* logic/dtec_timers.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - Timer source counts one per machine cycle of twelve clocks.
// - Event source sampled each machine cycle; high then low sample counts one.
// - Counted event readable no later than second machine cycle after edge.
// - Mode 00: high byte counter behind five-bit prescaler in low byte.
// - Mode 01: high and low bytes cascade into one 16-bit counter.
// - Mode 10: low byte counts, reloads from high byte on overflow.
// - Counter 0 split: low byte own controls, high byte timer on counter 1 run.
// - Counter 1 in mode 11 stops and holds its value.
// - Counter 0 split: counter 1 sets no flag, still feeds baud tick.
// - Gate set: count only while gate pin high and run set.
// - Source select clear picks internal clock, set picks event pin.
// - Mode field sits at bits 5:4 and 1:0, upper bit higher.
// - Overflow from all ones sets flag, except counter 1 during split.
// - Both counters configure independently into any of four modes.
// - Flag set by overflow, cleared by vector acknowledge.
// - Software run bit turns each counter on and off.
module dtec_timers #(
    parameter int MC_DIV = dtec_pkg::MC_PERIODS
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [2:0] busAddr,
    input  wire logic [7:0] busWrData,
    input  wire logic       busWr,
    input  wire logic       busRd,
    output var  logic [7:0] busRdData_q,
    // Event and gate pins
    input  wire logic       eventPinZero,
    input  wire logic       eventPinOne,
    input  wire logic [1:0] gateInterruptPin,
    // Interrupt vector acknowledge, one per counter
    input  wire logic [1:0] vectorAck,
    // Interrupt and baud rate outputs
    output var  logic       irq_q,
    output var  logic       baudTick_q
);
    localparam int MCW = (MC_DIV > 1) ? $clog2(MC_DIV) : 1;

    // Refuse dividers the tick logic cannot serve
    if (MC_DIV < 2) begin : gDivCheck
        $error("MC_DIV must be at least 2");
    end

    // Mode nibble of one counter
    function automatic logic [3:0] cfgNibble(input logic [7:0] m, input logic sel);
        return sel ? m[dtec_pkg::NIB_WIDTH +: dtec_pkg::NIB_WIDTH]
                   : m[0 +: dtec_pkg::NIB_WIDTH];
    endfunction : cfgNibble

    logic [MCW-1:0]       mcCnt_q;
    logic [1:0]           evtMeta_q;
    logic [1:0]           evtSync_q;
    logic [1:0]           evtSamp_q;
    logic [1:0]           gateMeta_q;
    logic [1:0]           gateSync_q;
    logic [7:0]           timerModeConfig_q;
    logic [1:0]           runCtrl_q;
    logic [1:0]           ovfFlag_q;
    logic [1:0]           ovfFlag_d;
    logic [1:0]           irqMask_q;
    logic [7:0]           rdMux;
    logic [3:0]           cfg [2];
    dtec_pkg::dtec_mode_t cfgMode [2];
    logic [1:0]           cfgGate;
    logic [1:0]           cfgSrc;
    logic [1:0]           evtFall;
    logic [1:0]           cntEnable;
    logic [1:0]           cntTick;
    logic [1:0]           flagSet;
    logic [1:0]           flagClr;
    logic                 mcTick;
    logic                 split0;
    logic                 wrMode;
    logic                 wrCtrl;
    logic                 wrStatus;
    logic                 wrMask;

    dtec_unit_if u0If ();
    dtec_unit_if u1If ();

    // Machine cycle divider
    assign mcTick = (mcCnt_q == MCW'(MC_DIV - 1));
    always_ff @(posedge clk) begin
        if (!rstn) begin
            mcCnt_q <= '0;
        end else begin
            mcCnt_q <= mcTick ? '0 : mcCnt_q + MCW'(1);
        end
    end

    // Pin synchronisers and once-per-machine-cycle event sample
    always_ff @(posedge clk) begin
        if (!rstn) begin
            evtMeta_q  <= 2'h0;
            evtSync_q  <= 2'h0;
            gateMeta_q <= 2'h0;
            gateSync_q <= 2'h0;
            evtSamp_q  <= 2'h0;
        end else begin
            evtMeta_q  <= {eventPinOne, eventPinZero};
            evtSync_q  <= evtMeta_q;
            gateMeta_q <= gateInterruptPin;
            gateSync_q <= gateMeta_q;
            if (mcTick) begin
                evtSamp_q <= evtSync_q;
            end
        end
    end

    // Per-counter configuration decode
    assign cfg[0]    = cfgNibble(timerModeConfig_q, 1'b0);
    assign cfg[1]    = cfgNibble(timerModeConfig_q, 1'b1);
    assign cfgMode[0] = dtec_pkg::dtec_mode_t'(cfg[0][dtec_pkg::MODE_POS +: dtec_pkg::MODE_WIDTH]);
    assign cfgMode[1] = dtec_pkg::dtec_mode_t'(cfg[1][dtec_pkg::MODE_POS +: dtec_pkg::MODE_WIDTH]);
    assign cfgGate   = {cfg[1][dtec_pkg::GATE_POS], cfg[0][dtec_pkg::GATE_POS]};
    assign cfgSrc    = {cfg[1][dtec_pkg::SRC_POS], cfg[0][dtec_pkg::SRC_POS]};
    assign split0    = (cfgMode[0] == dtec_pkg::MODE_SPLIT);

    // Count enables, source select and ticks
    assign evtFall    = evtSamp_q & ~evtSync_q;
    assign cntEnable  = runCtrl_q & (~cfgGate | gateSync_q);
    assign cntTick[0] = mcTick & cntEnable[0] & (cfgSrc[0] ? evtFall[0] : 1'b1);
    assign cntTick[1] = mcTick & cntEnable[1] & (cfgSrc[1] ? evtFall[1] : 1'b1)
                        & (cfgMode[1] != dtec_pkg::MODE_SPLIT);

    // Register write decode
    assign wrMode   = busWr && (busAddr == dtec_pkg::ADDR_MODE);
    assign wrCtrl   = busWr && (busAddr == dtec_pkg::ADDR_CTRL);
    assign wrStatus = busWr && (busAddr == dtec_pkg::ADDR_STATUS);
    assign wrMask   = busWr && (busAddr == dtec_pkg::ADDR_MASK);

    // Counter 0 unit, its high byte borrowed by counter 1 run bit in split
    assign u0If.mode     = cfgMode[0];
    assign u0If.tick     = cntTick[0];
    assign u0If.highTick = mcTick & runCtrl_q[dtec_pkg::CNT1_POS] & split0;
    assign u0If.wrLow    = busWr && (busAddr == dtec_pkg::ADDR_C0LOW);
    assign u0If.wrHigh   = busWr && (busAddr == dtec_pkg::ADDR_C0HIGH);
    assign u0If.wrData   = busWrData;

    // Counter 1 unit
    assign u1If.mode     = cfgMode[1];
    assign u1If.tick     = cntTick[1];
    assign u1If.highTick = 1'b0;
    assign u1If.wrLow    = busWr && (busAddr == dtec_pkg::ADDR_C1LOW);
    assign u1If.wrHigh   = busWr && (busAddr == dtec_pkg::ADDR_C1HIGH);
    assign u1If.wrData   = busWrData;

    dtec_count_unit uCnt0 (
        .clk  (clk),
        .rstn (rstn),
        .bus  (u0If.unit)
    );

    dtec_count_unit uCnt1 (
        .clk  (clk),
        .rstn (rstn),
        .bus  (u1If.unit)
    );

    // Flag set and clear; a set in the clearing cycle wins
    assign flagSet[0] = u0If.ovf;
    assign flagSet[1] = split0 ? u0If.ovfHigh : u1If.ovf;
    assign flagClr    = vectorAck | (wrStatus ? busWrData[1:0] : 2'h0);
    assign ovfFlag_d  = flagSet | (ovfFlag_q & ~flagClr);

    // Control registers and flags
    always_ff @(posedge clk) begin
        if (!rstn) begin
            timerModeConfig_q <= dtec_pkg::MODE_RST;
            runCtrl_q         <= dtec_pkg::CTRL_RST;
            irqMask_q         <= dtec_pkg::MASK_RST;
            ovfFlag_q         <= dtec_pkg::FLAG_RST;
        end else begin
            if (wrMode) begin
                timerModeConfig_q <= busWrData;
            end
            if (wrCtrl) begin
                runCtrl_q <= busWrData[1:0];
            end
            if (wrMask) begin
                irqMask_q <= busWrData[1:0];
            end
            ovfFlag_q <= ovfFlag_d;
        end
    end

    // Read selection
    always_comb begin
        if (busAddr == dtec_pkg::ADDR_MODE) begin
            rdMux = timerModeConfig_q;
        end else if (busAddr == dtec_pkg::ADDR_CTRL) begin
            rdMux = {6'h00, runCtrl_q};
        end else if (busAddr == dtec_pkg::ADDR_STATUS) begin
            rdMux = {6'h00, ovfFlag_q};
        end else if (busAddr == dtec_pkg::ADDR_MASK) begin
            rdMux = {6'h00, irqMask_q};
        end else if (busAddr == dtec_pkg::ADDR_C0LOW) begin
            rdMux = u0If.countLow;
        end else if (busAddr == dtec_pkg::ADDR_C0HIGH) begin
            rdMux = u0If.countHigh;
        end else if (busAddr == dtec_pkg::ADDR_C1LOW) begin
            rdMux = u1If.countLow;
        end else begin
            rdMux = u1If.countHigh;
        end
    end

    // Outputs: read data for one cycle, interrupt level, baud pulse
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busRdData_q <= 8'h00;
            irq_q       <= 1'b0;
            baudTick_q  <= 1'b0;
        end else begin
            busRdData_q <= busRd ? rdMux : 8'h00;
            irq_q       <= |(ovfFlag_q & irqMask_q);
            baudTick_q  <= u1If.ovf;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_mcPeriod;
        mcTick |-> ##12 mcTick;
    endproperty
    a_mcPeriod: assert property (p_mcPeriod) else $error("machine cycle not 12");
    property p_edgeOnly;
        mcTick && cfgSrc[0] && !(evtSamp_q[0] && !evtSync_q[0]) |-> !cntTick[0];
    endproperty
    a_edgeOnly: assert property (p_edgeOnly) else $error("count without falling edge");
    property p_gate;
        (cfgGate[0] && !gateSync_q[0]) || (cfgGate[1] && !gateSync_q[1])
            |-> !(cfgGate[0] && !gateSync_q[0] && cntTick[0])
                && !(cfgGate[1] && !gateSync_q[1] && cntTick[1]);
    endproperty
    a_gate: assert property (p_gate) else $error("counted with gate low");
    property p_runOff;
        !runCtrl_q[1] |-> !cntTick[1] && !u0If.highTick;
    endproperty
    a_runOff: assert property (p_runOff) else $error("counted with run clear");
    property p_hold1;
        cfgMode[1] == dtec_pkg::MODE_SPLIT && !u1If.wrLow && !u1If.wrHigh
            |=> $stable({u1If.countHigh, u1If.countLow});
    endproperty
    a_hold1: assert property (p_hold1) else $error("counter 1 moved in mode 11");
    property p_splitHigh;
        mcTick && runCtrl_q[1] && split0 |-> u0If.highTick;
    endproperty
    a_splitHigh: assert property (p_splitHigh) else $error("split high byte idle");
    property p_noFlag1;
        split0 && !u0If.ovfHigh && !ovfFlag_q[1] |=> !ovfFlag_q[1];
    endproperty
    a_noFlag1: assert property (p_noFlag1) else $error("counter 1 flag set in split");
    property p_baud;
        u1If.ovf |=> baudTick_q ##1 !baudTick_q;
    endproperty
    a_baud: assert property (p_baud) else $error("baud tick missing");
    property p_setWins;
        u0If.ovf |=> ovfFlag_q[0];
    endproperty
    a_setWins: assert property (p_setWins) else $error("overflow flag lost");
    property p_ackClr;
        vectorAck[0] && !u0If.ovf |=> !ovfFlag_q[0];
    endproperty
    a_ackClr: assert property (p_ackClr) else $error("acknowledge did not clear");
    property p_irq;
        |(ovfFlag_q & irqMask_q) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    property p_noIrq;
        (ovfFlag_q & irqMask_q) == 2'h0 |=> !irq_q;
    endproperty
    a_noIrq: assert property (p_noIrq) else $error("interrupt without cause");

    property p_mcRange;
        mcCnt_q <= MCW'(MC_DIV - 1);
    endproperty
    a_mcRange: assert property (p_mcRange) else $error("divider out of range");

    property p_mcOnly;
        !mcTick |-> cntTick == 2'h0 && !u0If.highTick;
    endproperty
    a_mcOnly: assert property (p_mcOnly) else $error("count off machine cycle");

    property p_timer0;
        mcTick && cntEnable[0] && !cfgSrc[0] |-> cntTick[0];
    endproperty
    a_timer0: assert property (p_timer0) else $error("counter 0 timer tick lost");

    property p_timer1;
        mcTick && cntEnable[1] && !cfgSrc[1]
            && cfgMode[1] != dtec_pkg::MODE_SPLIT |-> cntTick[1];
    endproperty
    a_timer1: assert property (p_timer1) else $error("counter 1 timer tick lost");

    property p_evtSamp;
        mcTick |=> evtSamp_q == $past(evtSync_q);
    endproperty
    a_evtSamp: assert property (p_evtSamp) else $error("event sample missed");

    property p_modeWr;
        wrMode |=> timerModeConfig_q == $past(busWrData);
    endproperty
    a_modeWr: assert property (p_modeWr) else $error("mode write lost");

    property p_ctrlWr;
        wrCtrl |=> {6'h00, runCtrl_q} == ($past(busWrData) & 8'h03);
    endproperty
    a_ctrlWr: assert property (p_ctrlWr) else $error("run write lost");

    property p_flagHold;
        ovfFlag_q[0] && !flagClr[0] |=> ovfFlag_q[0];
    endproperty
    a_flagHold: assert property (p_flagHold) else $error("flag lost without clear");

    property p_wrClr;
        wrStatus && busWrData[1] && !flagSet[1] |=> !ovfFlag_q[1];
    endproperty
    a_wrClr: assert property (p_wrClr) else $error("write one did not clear");

    property p_flag1Set;
        !split0 && u1If.ovf |=> ovfFlag_q[1];
    endproperty
    a_flag1Set: assert property (p_flag1Set) else $error("counter 1 flag not set");

    property p_rdIdle;
        !busRd |=> busRdData_q == 8'h00;
    endproperty
    a_rdIdle: assert property (p_rdIdle) else $error("read data outside read slot");

    property p_rdMode;
        busRd && busAddr == dtec_pkg::ADDR_MODE |=> busRdData_q == $past(timerModeConfig_q);
    endproperty
    a_rdMode: assert property (p_rdMode) else $error("mode readback wrong");

    c_baud:     cover property (u1If.ovf && split0);
    c_splitOvf: cover property (u0If.ovfHigh);
    c_evtCount: cover property (cntTick[0] && cfgSrc[0]);
    c_ackSet:   cover property (vectorAck[0] && u0If.ovf);
endmodule : dtec_timers
`default_nettype wire

/* test/dtec_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dtec_pin_model #(
    parameter int HOLD = 24
) (
    // Clock
    input  wire logic       clk,
    // Commands from the bench
    input  wire logic [1:0] pulseReq,
    input  wire logic [1:0] gateLvl,
    // Pins toward the block
    output var  logic       eventPinZero,
    output var  logic       eventPinOne,
    output var  logic [1:0] gateInterruptPin
);
    logic [7:0] hold0_q = 8'h00;
    logic [7:0] hold1_q = 8'h00;

    // Each pulse stays high a whole hold span, then the pin idles low
    always @(posedge clk) begin
        hold0_q <= pulseReq[0] ? 8'(HOLD) : hold0_q - {7'h00, hold0_q != 8'h00};
        hold1_q <= pulseReq[1] ? 8'(HOLD) : hold1_q - {7'h00, hold1_q != 8'h00};
    end

    // Pin levels, gates follow the bench directly
    always_comb begin
        eventPinZero     = (hold0_q != 8'h00);
        eventPinOne      = (hold1_q != 8'h00);
        gateInterruptPin = gateLvl;
    end
endmodule : dtec_pin_model
`default_nettype wire

/* test/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam int MCD  = 12;
    localparam int HOLD = 2 * MCD;
    logic       clk         = 1'b0;
    logic       rstn        = 1'b0;
    logic [2:0] busAddr     = 3'h0;
    logic [7:0] busWrData   = 8'h00;
    logic       busWr       = 1'b0;
    logic       busRd       = 1'b0;
    logic [7:0] busRdData_q;
    logic       eventPinZero;
    logic       eventPinOne;
    logic [1:0] gateInterruptPin;
    logic [1:0] vectorAck   = 2'h0;
    logic       irq_q;
    logic       baudTick_q;
    logic [1:0] pulseReq    = 2'h0;
    logic [1:0] gateLvl     = 2'h0;
    logic       rdPend      = 1'b0;
    logic [7:0] expQ[$];
    string      nameQ[$];
    int         failures    = 0;
    int         comparisons = 0;
    logic [7:0] rnd;
    int         k;

    // Clock generator
    always #10 clk = ~clk;

    dtec_timers #(.MC_DIV(MCD)) i_dtec_timers (
        .clk(clk), .rstn(rstn), .busAddr(busAddr), .busWrData(busWrData), .busWr(busWr),
        .busRd(busRd), .busRdData_q(busRdData_q), .eventPinZero(eventPinZero),
        .eventPinOne(eventPinOne), .gateInterruptPin(gateInterruptPin),
        .vectorAck(vectorAck), .irq_q(irq_q), .baudTick_q(baudTick_q));

    dtec_pin_model #(.HOLD(HOLD)) i_dtec_pin_model (
        .clk(clk), .pulseReq(pulseReq), .gateLvl(gateLvl), .eventPinZero(eventPinZero),
        .eventPinOne(eventPinOne), .gateInterruptPin(gateInterruptPin));

    task automatic cmp_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        busWr     <= 1'b1;
        busAddr   <= a;
        busWrData <= d;
        @(posedge clk);
        busWr     <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, input logic [7:0] e, input string what);
        expQ.push_back(e);
        nameQ.push_back(what);
        @(posedge clk);
        busRd   <= 1'b1;
        busAddr <= a;
        @(posedge clk);
        busRd   <= 1'b0;
    endtask : rd

    // Read data checked in the cycle after each read strobe
    always @(posedge clk) begin
        if (rdPend && expQ.size() > 0)
            cmp_val(nameQ.pop_front(), {8'h00, expQ.pop_front()}, {8'h00, busRdData_q});
        rdPend <= busRd;
    end

    task automatic wait_irq();
        for (int i = 0; i < 60 && irq_q !== 1'b1; i++) @(posedge clk);
        cmp_val("irq", 16'h0001, {15'h0000, irq_q});
    endtask : wait_irq

    task automatic baud_period(input logic [15:0] exp);
        logic [15:0] n;
        n = 16'h0000;
        for (int i = 0; i < 200 && baudTick_q !== 1'b1; i++) @(posedge clk);
        @(posedge clk);
        while (baudTick_q !== 1'b1 && n < 16'h00C8) begin
            n++;
            @(posedge clk);
        end
        cmp_val("baud period", exp, n + 16'h0001);
    endtask : baud_period

    task automatic pulse(input logic [7:0] expLow0);
        @(posedge clk);
        pulseReq <= 2'b11;
        @(posedge clk);
        pulseReq <= 2'b00;
        repeat (HOLD - 1) @(posedge clk);
        rd(dtec_pkg::ADDR_C0LOW, expLow0, "c0 low at edge");
        repeat (HOLD) @(posedge clk);
    endtask : pulse

    task automatic give_verdict();
        $display("TB: %0d comparisons, %0d failures", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict

    // Watchdog against a hang
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("ERROR watchdog expected finish seen timeout");
        give_verdict();
    end

    // Main sequence
    initial begin
        k = $urandom(51153);
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (k = 0; k < 8; k++) rd(3'(k), 8'h00, "reset value");
        rnd = 8'($urandom());
        wr(dtec_pkg::ADDR_MODE, rnd);
        rd(dtec_pkg::ADDR_MODE, rnd, "mode reg");
        $display("TEST registers done");
        // Counter 1 auto-reload timer, then counter 0 split
        wr(dtec_pkg::ADDR_C1LOW, 8'hFD);
        wr(dtec_pkg::ADDR_C1HIGH, 8'hFD);
        wr(dtec_pkg::ADDR_MODE, 8'h20);
        wr(dtec_pkg::ADDR_CTRL, 8'h02);
        baud_period(16'(3 * MCD));
        rd(dtec_pkg::ADDR_STATUS, 8'h02, "flag1");
        cmp_val("irq masked", 16'h0000, {15'h0000, irq_q});
        wr(dtec_pkg::ADDR_MODE, 8'h23);
        wr(dtec_pkg::ADDR_STATUS, 8'h02);
        baud_period(16'(3 * MCD));
        rd(dtec_pkg::ADDR_STATUS, 8'h00, "flag1 in split");
        wr(dtec_pkg::ADDR_CTRL, 8'h00);
        $display("TEST reload and split done");
        // Counter 1 stopped in mode 11
        rnd = 8'($urandom());
        wr(dtec_pkg::ADDR_C1LOW, rnd);
        wr(dtec_pkg::ADDR_MODE, 8'h30);
        wr(dtec_pkg::ADDR_CTRL, 8'h02);
        repeat (3 * MCD) @(posedge clk);
        rd(dtec_pkg::ADDR_C1LOW, rnd, "c1 held");
        wr(dtec_pkg::ADDR_CTRL, 8'h00);
        $display("TEST hold done");
        // Counter 0 16-bit overflow, cleared by acknowledge
        wr(dtec_pkg::ADDR_MASK, 8'h01);
        wr(dtec_pkg::ADDR_C0LOW, 8'hFF);
        wr(dtec_pkg::ADDR_C0HIGH, 8'hFF);
        wr(dtec_pkg::ADDR_MODE, 8'h01);
        wr(dtec_pkg::ADDR_CTRL, 8'h01);
        wait_irq();
        rd(dtec_pkg::ADDR_C0LOW, 8'h00, "c0 low wrap");
        rd(dtec_pkg::ADDR_C0HIGH, 8'h00, "c0 high wrap");
        rd(dtec_pkg::ADDR_STATUS, 8'h01, "flag0");
        @(posedge clk);
        vectorAck <= 2'b01;
        @(posedge clk);
        vectorAck <= 2'b00;
        rd(dtec_pkg::ADDR_STATUS, 8'h00, "flag0 acked");
        repeat (2) @(posedge clk);
        cmp_val("irq cleared", 16'h0000, {15'h0000, irq_q});
        $display("TEST cascade done");
        // Counter 0 prescaled mode
        wr(dtec_pkg::ADDR_CTRL, 8'h00);
        wr(dtec_pkg::ADDR_C0LOW, 8'hFF);
        wr(dtec_pkg::ADDR_C0HIGH, 8'hFF);
        wr(dtec_pkg::ADDR_MODE, 8'h00);
        wr(dtec_pkg::ADDR_CTRL, 8'h01);
        wait_irq();
        rd(dtec_pkg::ADDR_C0LOW, 8'hE0, "prescaler wrap");
        rd(dtec_pkg::ADDR_C0HIGH, 8'h00, "c0 high prescaled");
        wr(dtec_pkg::ADDR_STATUS, 8'h01);
        wr(dtec_pkg::ADDR_CTRL, 8'h00);
        $display("TEST prescale done");
        // Event counting, counter 1 gated, counter 0 free
        wr(dtec_pkg::ADDR_C0LOW, 8'h00);
        wr(dtec_pkg::ADDR_C1LOW, 8'h00);
        wr(dtec_pkg::ADDR_MODE, 8'hD5);
        wr(dtec_pkg::ADDR_CTRL, 8'h03);
        for (k = 0; k < 3; k++) pulse(8'(k));
        gateLvl <= 2'b11;
        repeat (4) @(posedge clk);
        for (k = 3; k < 6; k++) pulse(8'(k));
        repeat (2 * MCD) @(posedge clk);
        rd(dtec_pkg::ADDR_C0LOW, 8'h06, "c0 events");
        rd(dtec_pkg::ADDR_C1LOW, 8'h03, "c1 gated events");
        $display("TEST events done");
        repeat (5) @(posedge clk);
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
